// [hw/bac_top.sv]
// burst address counter of one dual-port ram port: counter, mask, mirror,
// wrap flag and pipelined readback onto the address pins.
// assumes the host drives ctl and addr_in on the same clock; only the
// global init input arrives asynchronously.
// limitation: an init pulse that starts and ends between two edges is
// invisible to the cause checks below, which may then flag a change.

`default_nettype none

module bac_top
	import bac_pkg::*;
(
	// clock, reset, enable
	input wire logic clock,
	input wire logic rstn,
	input wire logic clk_en,
	// asynchronous global initialisation
	input wire logic global_async_init_n,
	// host controls
	input wire bac_ctl_t ctl,
	input wire logic port_select_low_active,
	input wire logic port_select_high_active,
	// two-way address pins
	input wire bac_addr_t addr_in,
	output logic [ADDR_W-1:0] addr_out,
	output logic addr_oe,
	// towards array and data pins
	output logic [ADDR_W-1:0] array_addr,
	output logic wrap_flag_n,
	output logic dq_float
);

	bac_state_t s_q;
	bac_state_t s_d;
	bac_op_t op_raw;
	bac_op_t op;
	logic ready;
	logic selected;
	logic all_ones;
	bac_addr_t step;
	bac_addr_t inc_val;
	bac_addr_t inc_next;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------

	assign ready = s_q.init_sync[1];
	// the selects only steer dq_float; no command decode looks at them
	assign selected = !port_select_low_active
		&& port_select_high_active;

	always_comb begin
		op_raw = OP_HOLD;
		if (ctl.counter_or_mask_select) begin
			if (!ctl.count_clear_n) begin
				op_raw = OP_CLEAR;
			end else begin
				case ({ctl.addr_strobe_n, ctl.count_advance_n})
					2'b00: op_raw = OP_LOAD;
					2'b01: op_raw = OP_CNT_RB;
					2'b10: op_raw = OP_INC;
					default: op_raw = OP_HOLD;
				endcase
			end
		end else begin
			if (!ctl.count_clear_n) begin
				op_raw = OP_MASK_RST;
			end else begin
				case ({ctl.addr_strobe_n, ctl.count_advance_n})
					2'b00: op_raw = OP_MASK_LOAD;
					2'b01: op_raw = OP_MASK_RB;
					default: op_raw = OP_RSVD;
				endcase
			end
		end
		// controls are ignored until the init release has settled
		op = ready ? op_raw : OP_HOLD;
	end

	// ----------------------------------------------------------------
	// increment datapath
	// ----------------------------------------------------------------

	// masked bits are forced to one so the carry jumps over them,
	// then restored from the counter; no per-bit adder chain needed
	assign step = s_q.mask[0] ? STEP_ONE : STEP_TWO;
	assign all_ones = (s_q.cnt & s_q.mask) == s_q.mask;
	assign inc_val = (((s_q.cnt | ~s_q.mask) + step) & s_q.mask)
		| (s_q.cnt & ~s_q.mask);
	// with a full mask the wrap reload from mirror also
	assign inc_next = all_ones ? s_q.mir : inc_val;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------

	always_comb begin
		s_d = s_q;
		s_d.init_sync = {s_q.init_sync[0], 1'b1};
		case (op)
			OP_CLEAR: begin
				s_d.cnt = s_q.cnt & ~s_q.mask;
				s_d.mir = s_q.mir & ~s_q.mask;
				s_d.wrap_n = 1'b1;
			end
			OP_LOAD: begin
				s_d.cnt = addr_in;
				s_d.mir = addr_in;
				s_d.wrap_n = 1'b1;
			end
			OP_INC: begin
				s_d.cnt = inc_next;
				s_d.wrap_n = !((inc_next & s_q.mask) == s_q.mask);
			end
			OP_MASK_RST: begin
				s_d.mask = MASK_RESET;
				s_d.wrap_n = 1'b1;
			end
			OP_MASK_LOAD: begin
				s_d.mask = addr_in;
				s_d.wrap_n = 1'b1;
			end
			default: begin
				// hold, readbacks and the reserved code leave all three
				s_d.cnt = s_q.cnt;
			end
		endcase
		// one registered stage between command and pins gives the host a
		// whole cycle to release the address lines first
		// readback: sample now, drive the pins one edge later
		s_d.rb_pend = (op == OP_CNT_RB) || (op == OP_MASK_RB);
		s_d.rb_val = (op == OP_MASK_RB) ? s_q.mask : s_q.cnt;
		s_d.rb_sel = selected;
		s_d.addr_oe = s_q.rb_pend;
		s_d.addr_out = s_q.rb_pend ? s_q.rb_val : CNT_RESET;
		s_d.dq_float = s_q.rb_pend && s_q.rb_sel;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------

	// global init clears at once; the two-stage release keeps the
	// registers at their init values until the release is synchronous
	always_ff @(posedge clock or negedge global_async_init_n) begin
		if (!global_async_init_n) begin
			s_q <= ST_RESET;
		end else if (!rstn) begin
			s_q <= ST_RESET;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign array_addr = s_q.cnt;
	assign wrap_flag_n = s_q.wrap_n;
	assign addr_out = s_q.addr_out;
	assign addr_oe = s_q.addr_oe;
	assign dq_float = s_q.dq_float;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------

	logic live;
	assign live = clk_en && ready;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn || !global_async_init_n);

	a_load_both: assert property (
		live && op == OP_LOAD |=> array_addr == $past(addr_in)
			&& s_q.mir == $past(addr_in) && wrap_flag_n)
		else $error("load did not reach counter and mirror");

	a_clear_unmasked: assert property (
		live && op == OP_CLEAR |=>
			array_addr == ($past(s_q.cnt) & ~$past(s_q.mask))
			&& (s_q.mir & s_q.mask) == CNT_RESET && wrap_flag_n)
		else $error("clear changed masked bits or kept unmasked ones");

	a_hold_keeps: assert property (
		live && (op == OP_HOLD || op == OP_CNT_RB || op == OP_MASK_RB)
		|=> $stable(array_addr) && $stable(s_q.mask) && $stable(s_q.mir))
		else $error("hold or readback disturbed a register");

	a_inc_step: assert property (
		live && op == OP_INC && !all_ones |=>
			((array_addr & ~s_q.mask) == ($past(s_q.cnt) & ~s_q.mask))
			&& (((array_addr & s_q.mask) - ($past(s_q.cnt) & s_q.mask))
				== (s_q.mask[0] ? STEP_ONE : STEP_TWO)))
		else $error("increment step or masked bits wrong");

	a_inc_reload: assert property (
		live && op == OP_INC && all_ones |=> array_addr == $past(s_q.mir))
		else $error("wrap did not reload from mirror");

	a_wrap_flag: assert property (
		live && op == OP_INC |=>
			wrap_flag_n == ((array_addr & s_q.mask) != s_q.mask))
		else $error("wrap flag disagrees with counter");

	a_mask_reset: assert property (
		live && op == OP_MASK_RST |=> s_q.mask == MASK_RESET && wrap_flag_n)
		else $error("mask reset incomplete");

	a_mask_load: assert property (
		live && op == OP_MASK_LOAD |=> s_q.mask == $past(addr_in)
			&& wrap_flag_n)
		else $error("mask load did not copy address pins");

	a_cnt_readback: assert property (
		live && op == OP_CNT_RB ##1 clk_en |=>
			addr_oe && addr_out == $past(s_q.cnt, 2)
			&& dq_float == $past(selected, 2))
		else $error("counter readback not driven one cycle later");

	a_mask_readback: assert property (
		live && op == OP_MASK_RB ##1 clk_en |=>
			addr_oe && addr_out == $past(s_q.mask, 2))
		else $error("mask readback not driven one cycle later");

	a_addr_release: assert property (
		clk_en && !s_q.rb_pend |=> !addr_oe && !dq_float)
		else $error("address pins driven without readback");

	a_count_cause: assert property (
		$changed(array_addr) |-> !$past(rstn) || ($past(live)
			&& ($past(op) == OP_LOAD || $past(op) == OP_INC
			|| $past(op) == OP_CLEAR)))
		else $error("counter changed without a cause");

	// ----------------------------------------------------------------
	// assertions: what may move a register
	// ----------------------------------------------------------------

	// the mask moves only on its own two commands or a reset
	a_mask_cause: assert property (
		$changed(s_q.mask) |-> !$past(rstn) || ($past(live)
			&& ($past(op) == OP_MASK_LOAD || $past(op) == OP_MASK_RST)))
		else $error("mask changed without a mask command");

	// the mirror follows loads and clears only, never an increment
	a_mir_cause: assert property (
		$changed(s_q.mir) |-> !$past(rstn) || ($past(live)
			&& ($past(op) == OP_LOAD || $past(op) == OP_CLEAR)))
		else $error("mirror changed without a load or clear");

	a_wrap_low_cause: assert property (
		$fell(wrap_flag_n) |-> $past(live) && $past(op) == OP_INC)
		else $error("wrap flag fell without an increment");

	a_inc_mask_keep: assert property (
		live && op == OP_INC |=> $stable(s_q.mask) && $stable(s_q.mir))
		else $error("increment touched the mask or the mirror");

	a_load_mask_keep: assert property (
		live && (op == OP_LOAD || op == OP_CLEAR) |=> $stable(s_q.mask))
		else $error("counter command touched the mask");

	a_rsvd_hold: assert property (
		live && op == OP_RSVD |=> $stable(array_addr)
			&& $stable(s_q.mask) && $stable(s_q.mir)
			&& $stable(wrap_flag_n))
		else $error("reserved mask-mode code changed a register");

	a_wrap_keep: assert property (
		live && (op == OP_HOLD || op == OP_CNT_RB || op == OP_MASK_RB)
		|=> $stable(wrap_flag_n))
		else $error("hold or readback moved the wrap flag");

	a_clear_mirror: assert property (
		live && op == OP_CLEAR |=>
			(s_q.mir & ~s_q.mask) == ($past(s_q.mir) & ~s_q.mask))
		else $error("clear disturbed masked mirror bits");

	// away from a reload, a masked bit 0 never moves
	a_step_two: assert property (
		live && op == OP_INC && !s_q.mask[0] && !all_ones
		|=> $stable(array_addr[0]))
		else $error("masked bit 0 moved while counting by two");

	a_sweep_full: assert property (
		live && op == OP_INC && s_q.mask == MASK_RESET && !all_ones
		|=> array_addr == $past(array_addr) + STEP_ONE)
		else $error("full-mask increment did not step by one");

	// ----------------------------------------------------------------
	// assertions: readback pins
	// ----------------------------------------------------------------

	a_rb_pipe: assert property (
		clk_en && s_q.rb_pend |=> addr_oe)
		else $error("pending readback never reached the pins");

	a_float_with_oe: assert property (
		dq_float |-> addr_oe)
		else $error("data float raised outside a readback");

	a_out_idle_zero: assert property (
		!addr_oe |-> addr_out == CNT_RESET)
		else $error("address output not zero while released");

	a_mask_rb_float: assert property (
		live && op == OP_MASK_RB ##1 clk_en |=>
			dq_float == $past(selected, 2))
		else $error("mask readback float disagrees with the selects");

	// ----------------------------------------------------------------
	// assertions: enable, init and reset
	// ----------------------------------------------------------------

	// clk_en low freezes every register, readback pipeline included
	a_enable_freeze: assert property (
		!clk_en |=> $stable(s_q))
		else $error("state moved while the clock enable was low");

	a_not_ready_hold: assert property (
		clk_en && !ready |=> $stable(array_addr) && $stable(s_q.mask))
		else $error("controls acted before the init release settled");

	// these two run while the default disable would switch them off
	a_init_values: assert property (
		@(posedge clock) disable iff (1'b0)
		!global_async_init_n |-> array_addr == CNT_RESET
			&& s_q.mask == MASK_RESET && wrap_flag_n && !addr_oe)
		else $error("global init did not reset counter, mask or flag");

	a_rstn_values: assert property (
		@(posedge clock) disable iff (!global_async_init_n)
		!rstn |=> array_addr == CNT_RESET && s_q.mask == MASK_RESET
			&& wrap_flag_n && !addr_oe && !dq_float)
		else $error("synchronous reset did not restore the registers");

	// ----------------------------------------------------------------
	// cover points
	// ----------------------------------------------------------------

	c_load_then_inc: cover property (
		live && op == OP_LOAD ##1 live && op == OP_INC);
	c_wrap_reload: cover property (live && op == OP_INC && all_ones);
	c_cnt_readback: cover property (live && op == OP_CNT_RB ##2 addr_oe);
	c_count_by_two: cover property (live && op == OP_INC && !s_q.mask[0]);
	c_loop_clear: cover property (live && op == OP_CLEAR && !wrap_flag_n);

endmodule

`default_nettype wire

// [hw/bac_pkg.sv]
// constants, types and carriers for one port's burst address counter.
// assumes a single port clock; the host drives the controls on that clock.

`default_nettype none

package bac_pkg;

	// address width of the deepest variant; narrower parts drop top bits
	localparam int ADDR_W = 17;
	typedef logic [ADDR_W-1:0] bac_addr_t;

	localparam bac_addr_t CNT_RESET = 17'h00000;
	localparam bac_addr_t MASK_RESET = 17'h1ffff;
	localparam bac_addr_t STEP_ONE = 17'h00001;
	localparam bac_addr_t STEP_TWO = 17'h00002;
	localparam logic [1:0] INIT_SYNC_RESET = 2'h0;

	typedef enum logic [8:0] {
		OP_HOLD = 9'h001,
		OP_CLEAR = 9'h002,
		OP_LOAD = 9'h004,
		OP_CNT_RB = 9'h008,
		OP_INC = 9'h010,
		OP_MASK_RST = 9'h020,
		OP_MASK_LOAD = 9'h040,
		OP_MASK_RB = 9'h080,
		OP_RSVD = 9'h100
	} bac_op_t;

	// host control pins of the port, all sampled on the port clock
	typedef struct packed {
		logic counter_or_mask_select;
		logic count_clear_n;
		logic addr_strobe_n;
		logic count_advance_n;
	} bac_ctl_t;

	typedef struct packed {
		logic [1:0] init_sync;
		bac_addr_t cnt;
		bac_addr_t mask;
		bac_addr_t mir;
		logic wrap_n;
		logic rb_pend;
		logic rb_sel;
		bac_addr_t rb_val;
		bac_addr_t addr_out;
		logic addr_oe;
		logic dq_float;
	} bac_state_t;

	localparam bac_state_t ST_RESET = '{
		init_sync: INIT_SYNC_RESET,
		cnt: CNT_RESET,
		mask: MASK_RESET,
		mir: CNT_RESET,
		wrap_n: 1'b1,
		rb_pend: 1'b0,
		rb_sel: 1'b0,
		rb_val: CNT_RESET,
		addr_out: CNT_RESET,
		addr_oe: 1'b0,
		dq_float: 1'b0
	};

endpackage

`default_nettype wire

// [tb/bac_host.sv]
// host controller model for one port: control pins and address pins.
// assumes the bench sets cmd and host_addr at the port clock rise.
`default_nettype none
module bac_host
	import bac_pkg::*;
(
	// from the bench
	input wire bac_ctl_t cmd,
	input wire bac_addr_t host_addr,
	input wire logic loop_to_zero,
	// from the device
	input wire bac_addr_t addr_out,
	input wire logic addr_oe,
	input wire logic wrap_flag_n,
	// to the device
	output var bac_ctl_t ctl,
	output var bac_addr_t addr_in
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		ctl = cmd;
		// wrap flag wired straight onto clear, as a board would do it
		if (loop_to_zero) begin
			ctl.count_clear_n = cmd.count_clear_n & wrap_flag_n;
		end
		// host lets go of the pins while the device drives them
		addr_in = addr_oe ? addr_out : host_addr;
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench: table of commands, then readback, loop, init.
// assumes the host model resolves the shared address pins.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bac_pkg::*;
	typedef struct packed {
		logic [3:0] op;
		bac_addr_t a;
		bac_addr_t cnt;
		logic wrap;
	} bac_row_t;
	localparam logic [3:0] LD = 4'hc, INC = 4'he, HLD = 4'hf, RB = 4'hd;
	localparam logic [3:0] CLR = 4'hb, MRS = 4'h3, MLD = 4'h4, MRB = 4'h5;
	localparam bac_row_t ROWS [19] = '{
		'{MLD, 17'h0003f, 17'h00000, 1'b1},
		'{LD, 17'h0003c, 17'h0003c, 1'b1},
		'{INC, 17'h00000, 17'h0003d, 1'b1},
		'{INC, 17'h00000, 17'h0003e, 1'b1},
		'{INC, 17'h00000, 17'h0003f, 1'b0},
		'{HLD, 17'h00000, 17'h0003f, 1'b0},
		'{INC, 17'h00000, 17'h0003c, 1'b1},
		'{4'h6, 17'h00000, 17'h0003c, 1'b1},
		'{RB, 17'h00000, 17'h0003c, 1'b1},
		'{MLD, 17'h0003e, 17'h0003c, 1'b1},
		'{INC, 17'h00000, 17'h0003e, 1'b0},
		'{LD, 17'h1ffc7, 17'h1ffc7, 1'b1},
		'{CLR, 17'h00000, 17'h1ffc1, 1'b1},
		'{MRS, 17'h00000, 17'h1ffc1, 1'b1},
		'{CLR, 17'h00000, 17'h00000, 1'b1},
		'{LD, 17'h1fffe, 17'h1fffe, 1'b1},
		'{INC, 17'h00000, 17'h1ffff, 1'b0},
		'{MLD, 17'h1ffff, 17'h1ffff, 1'b1},
		'{INC, 17'h00000, 17'h1fffe, 1'b1}
	};
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic init_n = 1'b1;
	logic sel_lo = 1'b1;
	logic sel_hi = 1'b0;
	logic loop = 1'b0;
	logic clk_en = 1'b1;
	bac_ctl_t cmd = 4'hf;
	bac_addr_t host_addr = 17'h00000;
	bac_ctl_t ctl;
	bac_addr_t addr_in, addr_out, array_addr;
	logic addr_oe, wrap_flag_n, dq_float;
	int fail_count = 0;
	int n_compared = 0;
	always #2.5 clock = ~clock;
	bac_host u_bac_host (.cmd(cmd), .host_addr(host_addr),
		.loop_to_zero(loop), .addr_out(addr_out), .addr_oe(addr_oe),
		.wrap_flag_n(wrap_flag_n), .ctl(ctl), .addr_in(addr_in));
	bac_top u_bac_top (.clock(clock), .rstn(rstn), .clk_en(clk_en),
		.global_async_init_n(init_n), .ctl(ctl),
		.port_select_low_active(sel_lo), .port_select_high_active(sel_hi),
		.addr_in(addr_in), .addr_out(addr_out), .addr_oe(addr_oe),
		.array_addr(array_addr), .wrap_flag_n(wrap_flag_n),
		.dq_float(dq_float));
	// --------------------------------
	// checks and drivers
	// --------------------------------
	task automatic chk(input string what, input bac_addr_t exp, got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic chk_cw(input bac_addr_t c, input logic w);
		chk("array_addr", c, array_addr);
		chk("wrap_flag_n", {16'h0000, w}, {16'h0000, wrap_flag_n});
	endtask
	task automatic chk_rb(input bac_addr_t v, input logic oe, fl);
		chk("addr_out", v, addr_out);
		chk("addr_oe", {16'h0000, oe}, {16'h0000, addr_oe});
		chk("dq_float", {16'h0000, fl}, {16'h0000, dq_float});
	endtask
	task automatic step(input logic [3:0] op, input bac_addr_t a);
		@(posedge clock);
		cmd <= op;
		host_addr <= a;
	endtask
	task automatic conclude;
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
	// --------------------------------
	// sequence
	// --------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk_cw(17'h00000, 1'b1);
		$display("reset done");
		// selects wander on purpose: counting must not care
		for (int i = 0; i <= 19; i++) begin
			step(i < 19 ? ROWS[i].op : HLD, i < 19 ? ROWS[i].a : 17'h00000);
			sel_lo <= i[0];
			sel_hi <= i[1];
			#1;
			if (i > 0) chk_cw(ROWS[i-1].cnt, ROWS[i-1].wrap);
		end
		$display("table rows done");
		sel_lo <= 1'b0;
		sel_hi <= 1'b1;
		step(RB, 17'h00000);
		step(MRB, 17'h00000);
		sel_lo <= 1'b1;
		step(HLD, 17'h00000);
		#1 chk_rb(17'h1fffe, 1'b1, 1'b1);
		@(posedge clock);
		#1 chk_rb(17'h1ffff, 1'b1, 1'b0);
		@(posedge clock);
		#1 chk_rb(17'h00000, 1'b0, 1'b0);
		$display("readback done");
		step(MLD, 17'h00003);
		step(LD, 17'h00000);
		step(INC, 17'h00000);
		loop <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk_cw(17'h00003, 1'b0);
		@(posedge clock);
		#1 chk_cw(17'h00000, 1'b1);
		step(HLD, 17'h00000);
		loop <= 1'b0;
		$display("feedback loop done");
		#1 init_n <= 1'b0;
		#1 chk_cw(17'h00000, 1'b1);
		@(posedge clock);
		init_n <= 1'b1;
		repeat (2) @(posedge clock);
		step(INC, 17'h00000);
		repeat (3) @(posedge clock);
		#1 chk_cw(17'h00003, 1'b1);
		$display("global init done");
		// clock enable low freezes the counter in mid-increment
		@(posedge clock);
		clk_en <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chk_cw(17'h00004, 1'b1);
		@(posedge clock);
		clk_en <= 1'b1;
		@(posedge clock);
		#1 chk_cw(17'h00005, 1'b1);
		$display("clock enable done");
		@(posedge clock);
		rstn <= 1'b0;
		@(posedge clock);
		rstn <= 1'b1;
		#1 chk_cw(17'h00000, 1'b1);
		$display("mid-run reset done");
		conclude();
	end
endmodule
`default_nettype wire
